//--- rsc_top.sv
// Purpose: Merges power-on, pin, low-supply and watchdog resets.
// Assumes: rst_n_i is the power-on reset; pin and supply inputs are asynchronous.
// Notes: Registers on AHB-Lite, zero wait states, always OKAY.
`timescale 1ns/100ps

module rsc_top #(
   parameter bit LOWV_EN = 1'b1,
   parameter logic [10:0] LOW_SUPPLY_QUALIFY_TICKS = 11'(rsc_pkg::LOW_SUPPLY_QUALIFY_TICKS)
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic ext_nrst_pin_n_i,
   input wire logic low_supply_i,
   input wire logic watchdog_expiry_i,
   input wire logic sleep_cmd_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic core_run_o,
   output logic sleeping_o,
   output logic pc_clear_o,
   output logic sp_top_o,
   output logic watchdog_clear_o,
   output logic prescaler_clear_o,
   output logic timer_run_o,
   output logic [7:0] int_en_o,
   output logic [7:0] port_dir_o,
   output logic [7:0] port_data_o,
   output logic watchdog_expiry_flag_o,
   output logic sleep_entered_flag_o,
   output logic [2:0] reset_cause_o
);
   import rsc_pkg::*;

   typedef struct packed {
      rsc_state_t state;
      logic [10:0] wait_cnt;
      logic [7:0] tick_cnt;
      logic pin_s1;
      logic pin_s2;
      logic low_s1;
      logic low_s2;
      logic watchdog_expiry_flag;
      logic sleep_entered_flag;
      logic [2:0] cause;
      logic [7:0] int_en;
      logic timer_run;
      logic [7:0] port_dir;
      logic [7:0] port_data;
      logic pc_clr;
      logic sp_top;
      logic wdt_clr;
      logic pre_clr;
      logic wr_pend;
      logic [7:0] addr_q;
      logic [31:0] rdata;
      logic run;
      logic asleep;
   } rsc_st_t;

   rsc_st_t s_r;
   rsc_st_t s_nxt;
   rsc_lowv_if lif ();

   // Full reset of everything a pin, supply or running watchdog reset touches
   function automatic rsc_st_t full_reset(input rsc_st_t v);
      rsc_st_t r;
      r = v;
      r.int_en = INT_EN_RST;
      r.timer_run = 1'b0;
      r.pre_clr = 1'b1;
      r.port_dir = PORT_DIR_RST;
      r.port_data = PORT_DATA_RST;
      r.pc_clr = 1'b1;
      r.sp_top = 1'b1;
      r.wdt_clr = 1'b1;
      return r;
   endfunction : full_reset

   // Unmapped offsets read zero
   function automatic logic [31:0] reg_read(input logic [7:0] a, input rsc_st_t v);
      logic [31:0] d;
      d = 32'h0000_0000;
      if (a == OFS_STATUS) begin
         d[STAT_EXPIRY_BIT] = v.watchdog_expiry_flag;
         d[STAT_SLEEP_BIT] = v.sleep_entered_flag;
         d[STAT_RUN_BIT] = (v.state == RSC_RUN);
         d[STAT_CAUSE_LSB +: 3] = v.cause;
      end else if (a == OFS_INT_EN) begin
         d[7:0] = v.int_en;
      end else if (a == OFS_TIMER_CTRL) begin
         d[TCTL_RUN_BIT] = v.timer_run;
      end else if (a == OFS_PORT_DIR) begin
         d[7:0] = v.port_dir;
      end else if (a == OFS_PORT_DATA) begin
         d[7:0] = v.port_data;
      end
      return d;
   endfunction : reg_read

   // Pin outranks supply when both are seen together
   function automatic logic [2:0] ext_cause(input logic pin_seen);
      logic [2:0] c;
      c = CAUSE_LOW_SUPPLY;
      if (pin_seen) begin
         c = CAUSE_PIN;
      end
      return c;
   endfunction : ext_cause

   function automatic rsc_st_t wait_start(input rsc_st_t v);
      rsc_st_t r;
      r = v;
      r.state = RSC_WAIT;
      r.wait_cnt = 11'h000;
      return r;
   endfunction : wait_start

   logic accept;
   logic reset_req;
   logic tick;

   assign accept = hsel_i && hready_i && htrans_i[1];
   assign reset_req = !s_r.pin_s2 || lif.trip;
   // Divider restarts with the low level so the first tick is a full microsecond
   assign tick = s_r.low_s2 && (s_r.tick_cnt == TICK_LAST);
   assign lif.low_level = s_r.low_s2;
   assign lif.tick = tick;

   rsc_lowv_filter #(
      .LOWV_EN(LOWV_EN),
      .QUALIFY_TICKS(LOW_SUPPLY_QUALIFY_TICKS)
   ) u_lowv (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .lif(lif.filt)
   );

   always_comb begin
      s_nxt = s_r;
      s_nxt.pc_clr = 1'b0;
      s_nxt.sp_top = 1'b0;
      s_nxt.wdt_clr = 1'b0;
      s_nxt.pre_clr = 1'b0;
      s_nxt.pin_s1 = ext_nrst_pin_n_i;
      s_nxt.pin_s2 = s_r.pin_s1;
      s_nxt.low_s1 = low_supply_i;
      s_nxt.low_s2 = s_r.low_s1;
      if (!s_r.low_s2 || tick) begin
         s_nxt.tick_cnt = 8'h00;
      end else begin
         s_nxt.tick_cnt = s_r.tick_cnt + 8'h01;
      end

      // Bus write data phase
      if (s_r.wr_pend) begin
         if (s_r.addr_q == OFS_INT_EN) begin
            s_nxt.int_en = hwdata_i[7:0];
         end else if (s_r.addr_q == OFS_TIMER_CTRL) begin
            s_nxt.timer_run = hwdata_i[TCTL_RUN_BIT];
            s_nxt.pre_clr = hwdata_i[TCTL_PRE_CLR_BIT];
         end else if (s_r.addr_q == OFS_PORT_DIR) begin
            s_nxt.port_dir = hwdata_i[7:0];
         end else if (s_r.addr_q == OFS_PORT_DATA) begin
            s_nxt.port_data = hwdata_i[7:0];
         end
      end
      s_nxt.wr_pend = accept && hwrite_i;
      if (accept) begin
         s_nxt.addr_q = haddr_i[7:0];
      end

      // Reset sequencing; pin and supply outrank the watchdog
      case (s_r.state)
         RSC_HOLD: begin
            // Held in reset; software writes cannot stick
            s_nxt = full_reset(s_nxt);
            if (!reset_req) begin
               s_nxt = wait_start(s_nxt);
            end
         end
         RSC_WAIT: begin
            // A late pin or supply reset restarts the whole start-up
            if (reset_req) begin
               s_nxt = full_reset(s_nxt);
               s_nxt.cause = ext_cause(!s_r.pin_s2);
               s_nxt.state = RSC_HOLD;
            end else if (s_r.wait_cnt == STARTUP_LAST) begin
               s_nxt.state = RSC_RUN;
            end else begin
               s_nxt.wait_cnt = s_r.wait_cnt + 11'h001;
            end
         end
         RSC_RUN: begin
            if (reset_req) begin
               s_nxt = full_reset(s_nxt);
               s_nxt.cause = ext_cause(!s_r.pin_s2);
               s_nxt.state = RSC_HOLD;
            end else if (watchdog_expiry_i) begin
               s_nxt = full_reset(s_nxt);
               s_nxt.watchdog_expiry_flag = 1'b1;
               s_nxt.cause = CAUSE_WDT_RUN;
               s_nxt = wait_start(s_nxt);
            end else if (sleep_cmd_i) begin
               s_nxt.sleep_entered_flag = 1'b1;
               s_nxt.watchdog_expiry_flag = 1'b0;
               s_nxt.wdt_clr = 1'b1;
               s_nxt.state = RSC_SLEEP;
            end
         end
         RSC_SLEEP: begin
            if (reset_req) begin
               s_nxt = full_reset(s_nxt);
               s_nxt.cause = ext_cause(!s_r.pin_s2);
               s_nxt.state = RSC_HOLD;
            end else if (watchdog_expiry_i) begin
               // Only program counter and stack pointer; all else kept
               s_nxt.pc_clr = 1'b1;
               s_nxt.sp_top = 1'b1;
               s_nxt.watchdog_expiry_flag = 1'b1;
               s_nxt.cause = CAUSE_WDT_SLEEP;
               s_nxt = wait_start(s_nxt);
            end
         end
         default: begin
            s_nxt = full_reset(s_nxt);
            s_nxt.state = RSC_HOLD;
         end
      endcase

      // Registered so run and sleep outputs come straight from flops
      s_nxt.run = (s_nxt.state == RSC_RUN);
      s_nxt.asleep = (s_nxt.state == RSC_SLEEP);

      // Read sees the write of the same cycle
      if (accept && !hwrite_i) begin
         s_nxt.rdata = reg_read(haddr_i[7:0], s_nxt);
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_r <= '0;
         s_r.state <= RSC_HOLD;
         s_r.watchdog_expiry_flag <= 1'b0;
         s_r.sleep_entered_flag <= 1'b0;
         s_r.cause <= CAUSE_POWER_ON;
         s_r.int_en <= INT_EN_RST;
         s_r.port_dir <= PORT_DIR_RST;
         s_r.port_data <= PORT_DATA_RST;
         s_r.pc_clr <= 1'b1;
         s_r.sp_top <= 1'b1;
         s_r.wdt_clr <= 1'b1;
         s_r.pre_clr <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign hrdata_o = s_r.rdata;
   // No wait states; every register answers at once
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign core_run_o = s_r.run;
   assign sleeping_o = s_r.asleep;
   assign pc_clear_o = s_r.pc_clr;
   assign sp_top_o = s_r.sp_top;
   assign watchdog_clear_o = s_r.wdt_clr;
   assign prescaler_clear_o = s_r.pre_clr;
   assign timer_run_o = s_r.timer_run;
   assign int_en_o = s_r.int_en;
   assign port_dir_o = s_r.port_dir;
   assign port_data_o = s_r.port_data;
   assign watchdog_expiry_flag_o = s_r.watchdog_expiry_flag;
   assign sleep_entered_flag_o = s_r.sleep_entered_flag;
   assign reset_cause_o = s_r.cause;

endmodule : rsc_top

//--- rsc_pkg.sv
// Purpose: Shared constants and types of the reset source controller.
// Assumes: 250 MHz system clock, 32-bit AHB-Lite register port.
// Notes: All offsets are byte addresses of aligned words.
package rsc_pkg;

   // Timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int STARTUP_WAIT_CYC = 1024;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
   localparam int LOW_SUPPLY_QUALIFY_TIME_MS = 1;
   localparam int LOW_SUPPLY_QUALIFY_TICKS = (LOW_SUPPLY_QUALIFY_TIME_MS * 1000000) / TICK_NS;
   localparam logic [10:0] STARTUP_LAST = 11'(STARTUP_WAIT_CYC - 1);
   localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);

   // Register byte offsets
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_INT_EN = 8'h04;
   localparam logic [7:0] OFS_TIMER_CTRL = 8'h08;
   localparam logic [7:0] OFS_PORT_DIR = 8'h0c;
   localparam logic [7:0] OFS_PORT_DATA = 8'h10;

   // Field positions
   localparam int STAT_EXPIRY_BIT = 0;
   localparam int STAT_SLEEP_BIT = 1;
   localparam int STAT_RUN_BIT = 2;
   localparam int STAT_CAUSE_LSB = 4;
   localparam int TCTL_RUN_BIT = 0;
   localparam int TCTL_PRE_CLR_BIT = 1;

   // Values after reset
   localparam logic [7:0] INT_EN_RST = 8'h00;
   localparam logic [7:0] PORT_DIR_RST = 8'hff;
   localparam logic [7:0] PORT_DATA_RST = 8'hff;

   // Last reset cause
   localparam logic [2:0] CAUSE_POWER_ON = 3'h1;
   localparam logic [2:0] CAUSE_PIN = 3'h2;
   localparam logic [2:0] CAUSE_LOW_SUPPLY = 3'h3;
   localparam logic [2:0] CAUSE_WDT_RUN = 3'h4;
   localparam logic [2:0] CAUSE_WDT_SLEEP = 3'h5;

   typedef enum logic [3:0] {
      RSC_HOLD = 4'h1,
      RSC_WAIT = 4'h2,
      RSC_RUN = 4'h4,
      RSC_SLEEP = 4'h8
   } rsc_state_t;

endpackage : rsc_pkg

//--- rsc_lowv_if.sv
// Purpose: Carries the low-supply level, qualify tick and trip.
// Assumes: All signals on clock_i.
// Notes: The level is already synchronised by the top.
`timescale 1ns/100ps
interface rsc_lowv_if;
   logic low_level;
   logic tick;
   logic trip;
   modport filt (input low_level, input tick, output trip);
   modport ctl (output low_level, output tick, input trip);
endinterface : rsc_lowv_if

//--- rsc_lowv_filter.sv
// Purpose: Qualifies the low-supply indication before it may reset.
// Assumes: One tick per microsecond, aligned to the start of the low level.
// Notes: Disabled builds never trip.
`timescale 1ns/100ps
module rsc_lowv_filter #(
   parameter bit LOWV_EN = 1'b1,
   parameter logic [10:0] QUALIFY_TICKS = 11'd1000
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   rsc_lowv_if.filt lif
);
   import rsc_pkg::*;

   typedef struct packed {
      logic [10:0] cnt;
      logic trip;
   } rsc_filt_st_t;

   rsc_filt_st_t s_r;
   rsc_filt_st_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (!lif.low_level) begin
         s_nxt.cnt = 11'h000;
         s_nxt.trip = 1'b0;
      end else if (lif.tick) begin
         // One extra tick so that exactly the qualify time never trips
         if (s_r.cnt == QUALIFY_TICKS) begin
            s_nxt.trip = 1'b1;
         end else begin
            s_nxt.cnt = s_r.cnt + 11'h001;
         end
      end
      if (!LOWV_EN) begin
         s_nxt.trip = 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign lif.trip = s_r.trip;

endmodule : rsc_lowv_filter

//--- rsc_top_assertions.sv
// Purpose: Port-level timing checks of the reset source controller.
// Assumes: One clock; rst_n_i is the power-on reset.
// Notes: Bounds leave a few cycles for pin and supply synchronisers.
`timescale 1ns/100ps
module rsc_checker #(
   parameter bit LOWV_EN = 1'b1,
   parameter logic [10:0] LOW_SUPPLY_QUALIFY_TICKS = 11'd1000
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic low_supply_i,
   input wire logic watchdog_expiry_i,
   input wire logic sleep_cmd_i,
   input wire logic core_run_o,
   input wire logic sleeping_o,
   input wire logic pc_clear_o,
   input wire logic sp_top_o,
   input wire logic watchdog_clear_o,
   input wire logic timer_run_o,
   input wire logic [7:0] int_en_o,
   input wire logic [7:0] port_dir_o,
   input wire logic watchdog_expiry_flag_o,
   input wire logic sleep_entered_flag_o,
   input wire logic [2:0] reset_cause_o
);
   import rsc_pkg::*;
   localparam int TRIP_CYC = int'(LOW_SUPPLY_QUALIFY_TICKS) * TICK_CYC;
   localparam int LIM = TRIP_CYC + TICK_CYC + 8;
   logic [19:0] low_cnt;
   logic [10:0] wait_cnt;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // Saturate so long dips cannot wrap
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         low_cnt <= 20'h0;
         wait_cnt <= 11'h0;
      end else begin
         low_cnt <= !low_supply_i ? 20'h0 : low_cnt + 20'(low_cnt != 20'hfffff);
         wait_cnt <= (pc_clear_o || core_run_o) ? 11'h0 : wait_cnt + 11'(wait_cnt != 11'h7ff);
      end
   end
   property p_por;
      $rose(rst_n_i) |-> !watchdog_expiry_flag_o && !sleep_entered_flag_o && int_en_o == 8'h00
         && port_dir_o == 8'hff && !timer_run_o && pc_clear_o && sp_top_o && watchdog_clear_o;
   endproperty
   a_por: assert property (p_por) else $error("bad power-on state");
   property p_wait;
      $rose(core_run_o) |-> wait_cnt >= 11'd1020;
   endproperty
   a_wait: assert property (p_wait) else $error("start-up wait short");
   property p_flags;
      (watchdog_expiry_flag_o != $past(watchdog_expiry_flag_o))
         || (sleep_entered_flag_o != $past(sleep_entered_flag_o))
         |-> $past(watchdog_expiry_i) || $past(sleep_cmd_i);
   endproperty
   a_flags: assert property (p_flags) else $error("flag changed without cause");
   property p_sleep;
      sleep_cmd_i && core_run_o |=> sleeping_o && sleep_entered_flag_o && !watchdog_expiry_flag_o;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
   property p_wdt_run;
      watchdog_expiry_i && core_run_o |=> watchdog_expiry_flag_o && !core_run_o && pc_clear_o
         && int_en_o == 8'h00 && sleep_entered_flag_o == $past(sleep_entered_flag_o);
   endproperty
   a_wdt_run: assert property (p_wdt_run) else $error("run expiry wrong");
   property p_wdt_sleep;
      watchdog_expiry_i && sleeping_o |=> watchdog_expiry_flag_o && sleep_entered_flag_o
         && pc_clear_o && sp_top_o && $stable(int_en_o) && $stable(port_dir_o);
   endproperty
   a_wdt_sleep: assert property (p_wdt_sleep) else $error("sleep expiry wrong");
   property p_lowv;
      $fell(core_run_o) && reset_cause_o == CAUSE_LOW_SUPPLY |-> LOWV_EN && low_cnt > TRIP_CYC;
   endproperty
   a_lowv: assert property (p_lowv) else $error("supply trip too early");
   property p_lowv_late;
      LOWV_EN && low_cnt == LIM |-> !core_run_o;
   endproperty
   a_lowv_late: assert property (p_lowv_late) else $error("supply trip missing");
endmodule : rsc_checker

bind rsc_top rsc_checker #(.LOWV_EN(LOWV_EN),
   .LOW_SUPPLY_QUALIFY_TICKS(LOW_SUPPLY_QUALIFY_TICKS)) u_chk (.clock_i, .rst_n_i,
   .low_supply_i, .watchdog_expiry_i, .sleep_cmd_i, .core_run_o, .sleeping_o, .pc_clear_o,
   .sp_top_o, .watchdog_clear_o, .timer_run_o, .int_en_o, .port_dir_o,
   .watchdog_expiry_flag_o, .sleep_entered_flag_o, .reset_cause_o);

//--- rsc_supply_model.sv
// Purpose: Reset pin and supply detector beside the controller.
// Assumes: Levels change just after a rising edge.
// Notes: Pin has a pull-up, so released reads high.
`timescale 1ns/100ps
module rsc_supply_model (
   input wire logic clock_i,
   output logic ext_nrst_pin_n_o,
   output logic low_supply_o
);
   initial begin
      ext_nrst_pin_n_o = 1'b1;
      low_supply_o = 1'b0;
   end
   task automatic hold_pin(input int n);
      @(posedge clock_i);
      ext_nrst_pin_n_o <= 1'b0;
      repeat (n) @(posedge clock_i);
      ext_nrst_pin_n_o <= 1'b1;
      #1;
   endtask : hold_pin
   task automatic hold_low(input int n);
      @(posedge clock_i);
      low_supply_o <= 1'b1;
      repeat (n) @(posedge clock_i);
      low_supply_o <= 1'b0;
      #1;
   endtask : hold_low
endmodule : rsc_supply_model

//--- reset_source_controller_test.sv
// Purpose: Directed bench of the reset source controller.
// Assumes: Zero-wait bus slave; qualify count cut to 3 ticks.
// Notes: Every scenario drives and judges itself.
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
   $display("Error at %0t: got %h expected %h", $time, a, e); end end
module reset_source_controller_test;
   import rsc_pkg::*;
   localparam logic [10:0] QT = 11'd3;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic watchdog_expiry_i = 1'b0, sleep_cmd_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
   logic [1:0] htrans_i = 2'h0;
   logic [2:0] hsize_i = 3'h2;
   logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, rd;
   logic ext_nrst_pin_n_i, low_supply_i, hreadyout_o, core_run_o, sleeping_o, pc_clear_o;
   logic sp_top_o, watchdog_clear_o, prescaler_clear_o, timer_run_o, hresp_o;
   logic watchdog_expiry_flag_o, sleep_entered_flag_o;
   logic [7:0] int_en_o, port_dir_o, port_data_o;
   logic [2:0] reset_cause_o;
   int bad_count = 0;
   int checks = 0;
   always #2 clock_i = ~clock_i;
   rsc_supply_model u_far (.clock_i, .ext_nrst_pin_n_o(ext_nrst_pin_n_i),
      .low_supply_o(low_supply_i));
   rsc_top #(.LOW_SUPPLY_QUALIFY_TICKS(QT)) dut (.clock_i, .rst_n_i, .ext_nrst_pin_n_i,
      .low_supply_i, .watchdog_expiry_i, .sleep_cmd_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
      .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
      .core_run_o, .sleeping_o, .pc_clear_o, .sp_top_o, .watchdog_clear_o, .prescaler_clear_o,
      .timer_run_o, .int_en_o, .port_dir_o, .port_data_o, .watchdog_expiry_flag_o,
      .sleep_entered_flag_o, .reset_cause_o);
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test
   // Bounded wait for the bus ready; no slave may hang the run
   task automatic ready;
      int n;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (hreadyout_o !== 1'b1 && n < 20);
      if (hreadyout_o !== 1'b1) begin
         bad_count++;
         end_of_test;
      end
   endtask : ready
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clock_i);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      hwrite_i <= w;
      haddr_i <= {24'h0, a};
      ready;
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= wd;
      ready;
      rd = hrdata_o;
      #1;
   endtask : bus
   task automatic pulse(input logic w);
      @(posedge clock_i);
      watchdog_expiry_i <= w;
      sleep_cmd_i <= !w;
      @(posedge clock_i);
      watchdog_expiry_i <= 1'b0;
      sleep_cmd_i <= 1'b0;
      #1;
   endtask : pulse
   task automatic wait_run(output int n);
      n = 0;
      while (core_run_o !== 1'b1 && n < 1200) begin
         @(posedge clock_i);
         #1;
         n++;
      end
      if (core_run_o !== 1'b1) begin
         bad_count++;
         end_of_test;
      end
   endtask : wait_run
   task automatic t_por;
      int n;
      `CHK({int_en_o, port_dir_o, port_data_o, timer_run_o}, 25'h001_fffe)
      `CHK({pc_clear_o, sp_top_o, watchdog_clear_o, prescaler_clear_o}, 4'hf)
      `CHK({watchdog_expiry_flag_o, sleep_entered_flag_o}, 2'b00)
      bus(1'b1, OFS_STATUS, 32'hffff_ffff);
      bus(1'b0, OFS_STATUS, 32'h0);
      `CHK(rd, {25'h0, CAUSE_POWER_ON, 4'h0})
      bus(1'b0, 8'h20, 32'h0);
      `CHK(rd, 32'h0)
      `CHK(hresp_o, 1'b0)
      wait_run(n);
      // Three bus transfers of three edges each ran before the count began
      `CHK(n + 9 >= STARTUP_WAIT_CYC, 1'b1)
   endtask : t_por
   task automatic t_wdt_run;
      int n;
      bus(1'b1, OFS_TIMER_CTRL, 32'h3);
      `CHK(prescaler_clear_o, 1'b1)
      bus(1'b1, OFS_PORT_DATA, 32'h3c);
      `CHK({timer_run_o, port_data_o}, 9'h13c)
      pulse(1'b1);
      `CHK({watchdog_expiry_flag_o, sleep_entered_flag_o, core_run_o}, 3'b100)
      `CHK({timer_run_o, port_data_o}, 9'h0ff)
      wait_run(n);
      `CHK(n, STARTUP_WAIT_CYC)
   endtask : t_wdt_run
   task automatic t_sleep;
      int n;
      bus(1'b1, OFS_INT_EN, 32'h5a);
      bus(1'b1, OFS_PORT_DIR, 32'h0f);
      pulse(1'b0);
      `CHK({sleeping_o, sleep_entered_flag_o, watchdog_expiry_flag_o}, 3'b110)
      pulse(1'b1);
      `CHK({watchdog_expiry_flag_o, sleep_entered_flag_o}, 2'b11)
      `CHK({pc_clear_o, sp_top_o, watchdog_clear_o, int_en_o, port_dir_o}, 19'h65a0f)
      wait_run(n);
   endtask : t_sleep
   task automatic t_pin;
      int n;
      bus(1'b1, OFS_INT_EN, 32'h33);
      u_far.hold_pin(10);
      `CHK({core_run_o, pc_clear_o, int_en_o, port_dir_o}, 18'h100ff)
      `CHK({watchdog_expiry_flag_o, sleep_entered_flag_o}, 2'b11)
      wait_run(n);
      `CHK(reset_cause_o, CAUSE_PIN)
   endtask : t_pin
   task automatic t_lowv;
      int n;
      u_far.hold_low(QT * TICK_CYC);
      repeat (8) @(posedge clock_i);
      #1;
      `CHK(core_run_o, 1'b1)
      u_far.hold_low((QT + 2) * TICK_CYC);
      `CHK({core_run_o, reset_cause_o}, {1'b0, CAUSE_LOW_SUPPLY})
      `CHK({watchdog_expiry_flag_o, sleep_entered_flag_o}, 2'b11)
      wait_run(n);
   endtask : t_lowv
   // Power drops again with both flags set; both must clear
   task automatic t_repower;
      int n;
      @(posedge clock_i);
      rst_n_i <= 1'b0;
      repeat (4) @(posedge clock_i);
      rst_n_i <= 1'b1;
      #1;
      `CHK({watchdog_expiry_flag_o, sleep_entered_flag_o, reset_cause_o}, 5'h01)
      wait_run(n);
   endtask : t_repower
   initial begin
      repeat (16) @(posedge clock_i);
      rst_n_i <= 1'b1;
      #1;
      t_por;
      t_wdt_run;
      t_sleep;
      t_pin;
      t_lowv;
      t_repower;
      end_of_test;
   end
endmodule : reset_source_controller_test
